// File: logic/amp_host.sv
/*
 * Host controller for a flash device on its address-multiplexed parallel port.
 * Assumes the device samples address and data on the write strobe rising edge,
 * and that the board resolves the shared data wires from the enables.
 */
// Overview of operation
// - Shared pins carry row then column
// - Row select marks which half drives
// - Data written out, read back in
// - Hold address, data across strobe rise
`timescale 1ns/1ps
module amp_host #(
	parameter logic LARGE = 1'b0
) (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic                               req_valid,
	input  wire amp_pkg::amp_req_t                  req,
	input  wire logic                               top_protect_en,
	input  wire logic                               low_protect_en,
	output logic                                    req_ready,
	output logic                                    rsp_valid,
	output logic [amp_pkg::AMP_DATA_W-1:0]          rsp_data,
	output logic                                    device_ready,
	output logic                                    top_block_protect_n,
	output logic                                    lower_protect_n,
	output logic [amp_pkg::AMP_ROW_W-1:0]           addr_pins,
	output logic                                    row_col,
	output logic                                    we_n,
	output logic                                    oe_n,
	output logic [amp_pkg::AMP_DATA_W-1:0]          dq_out,
	output logic                                    dq_oe_n,
	input  wire logic [amp_pkg::AMP_DATA_W-1:0]     dq_in,
	input  wire logic                               ready_busy_n
);

	// ************************************************************
	// Pin synchronisers.
	// ************************************************************
	logic [amp_pkg::AMP_DATA_W:0] pins_sync;
	wire  [amp_pkg::AMP_DATA_W-1:0] dq_sync = pins_sync[amp_pkg::AMP_DATA_W-1:0];
	wire                            rdy_sync = pins_sync[amp_pkg::AMP_DATA_W];

	amp_sync #(.W(amp_pkg::AMP_DATA_W + 1)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({ready_busy_n, dq_in}),
		.q   (pins_sync)
	);

	// ************************************************************
	// Sequencer.
	// ************************************************************
	amp_pkg::amp_state_t state_reg, state_next;
	amp_pkg::amp_req_t   req_reg;
	amp_pkg::amp_pins_t  pins_reg, pins_next;
	logic [3:0]          cnt_reg;
	logic                done_reg;

	wire start     = req_valid && (state_reg == amp_pkg::AMP_IDLE);
	wire cnt_zero  = (cnt_reg == 4'h0);
	wire [amp_pkg::AMP_ROW_W-1:0] col_part =
		{2'h0, req_reg.addr[amp_pkg::AMP_ADDR_W-1:amp_pkg::AMP_ROW_W]};
	wire [3:0] set_setup = 4'(amp_pkg::AMP_SETUP_CYC - 1);
	wire [3:0] set_pulse = 4'(amp_pkg::AMP_PULSE_CYC - 1);
	wire [3:0] set_hold  = 4'(amp_pkg::AMP_HOLD_CYC - 1);
	wire [3:0] set_read  = 4'(amp_pkg::AMP_READ_CYC - 1);

	always_comb begin
		state_next = state_reg;
		pins_next  = pins_reg;
		case (state_reg)
			amp_pkg::AMP_IDLE: begin
				pins_next.we_n    = 1'b1;
				pins_next.oe_n    = 1'b1;
				pins_next.dq_oe_n = 1'b1;
				if (start) begin
					state_next        = amp_pkg::AMP_ROW;
					pins_next.addr    = req.addr[amp_pkg::AMP_ROW_W-1:0];
					pins_next.row_col = 1'b1;
				end
			end
			amp_pkg::AMP_ROW: begin
				if (cnt_zero) begin
					state_next        = amp_pkg::AMP_COL;
					pins_next.addr    = col_part;
					pins_next.row_col = 1'b0;
				end
			end
			amp_pkg::AMP_COL: begin
				if (cnt_zero) begin
					if (req_reg.write) begin
						state_next        = amp_pkg::AMP_STROB;
						pins_next.we_n    = 1'b0;
						pins_next.dq_out  = req_reg.wdata;
						pins_next.dq_oe_n = 1'b0;
					end else begin
						state_next     = amp_pkg::AMP_READ;
						pins_next.oe_n = 1'b0;
					end
				end
			end
			amp_pkg::AMP_STROB: begin
				if (cnt_zero) begin
					state_next     = amp_pkg::AMP_HOLD;
					pins_next.we_n = 1'b1;
				end
			end
			amp_pkg::AMP_HOLD: begin
				if (cnt_zero) begin
					state_next        = amp_pkg::AMP_DONE;
					pins_next.dq_oe_n = 1'b1;
				end
			end
			amp_pkg::AMP_READ: begin
				if (cnt_zero) begin
					state_next     = amp_pkg::AMP_DONE;
					pins_next.oe_n = 1'b1;
				end
			end
			amp_pkg::AMP_DONE: begin
				state_next = amp_pkg::AMP_IDLE;
			end
			default: begin
				state_next = amp_pkg::AMP_IDLE;
			end
		endcase
	end

	wire entering = (state_next != state_reg);
	wire [3:0] cnt_load =
		(state_next == amp_pkg::AMP_STROB) ? set_pulse :
		(state_next == amp_pkg::AMP_HOLD)  ? set_hold  :
		(state_next == amp_pkg::AMP_READ)  ? set_read  : set_setup;
	wire [3:0] cnt_next = entering ? cnt_load : (cnt_zero ? 4'h0 : cnt_reg - 4'h1);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= amp_pkg::AMP_IDLE;
			pins_reg  <= '{addr: '0, row_col: 1'b1, we_n: 1'b1, oe_n: 1'b1,
			               dq_out: '0, dq_oe_n: 1'b1};
			cnt_reg   <= 4'h0;
			req_reg   <= '0;
		end else begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			cnt_reg   <= cnt_next;
			if (start) begin
				req_reg <= req;
			end
		end
	end

	// ************************************************************
	// Answers and protect pins.
	// ************************************************************
	wire read_end = (state_reg == amp_pkg::AMP_READ) && cnt_zero;

	always_ff @(posedge clk) begin
		if (rst) begin
			done_reg            <= 1'b0;
			rsp_data            <= 8'h00;
			req_ready           <= 1'b0;
			device_ready        <= 1'b0;
			top_block_protect_n <= 1'b0;
			lower_protect_n     <= 1'b0;
		end else begin
			done_reg  <= (state_next == amp_pkg::AMP_DONE) && entering;
			req_ready <= (state_next == amp_pkg::AMP_IDLE) && !start;
			if (read_end) begin
				rsp_data <= dq_sync;
			end
			device_ready        <= rdy_sync;
			top_block_protect_n <= !top_protect_en;
			lower_protect_n     <= !low_protect_en;
		end
	end

	assign rsp_valid = done_reg;
	assign addr_pins = pins_reg.addr;
	assign row_col   = pins_reg.row_col;
	assign we_n      = pins_reg.we_n;
	assign oe_n      = pins_reg.oe_n;
	assign dq_out    = pins_reg.dq_out;
	assign dq_oe_n   = pins_reg.dq_oe_n;

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	top_protect_follows_a: assert property (
		top_protect_en |=> !top_block_protect_n)
		else $error("top protect pin not low");
	low_protect_follows_a: assert property (
		!low_protect_en |=> lower_protect_n)
		else $error("lower protect pin not released");
	row_then_col_a: assert property (
		$fell(row_col) |-> $past(state_reg) == amp_pkg::AMP_ROW)
		else $error("column phase not after row phase");
	write_data_held_a: assert property (
		$rose(we_n) |-> !dq_oe_n && $stable(dq_out) && $stable(addr_pins))
		else $error("data or address moved at strobe rise");
	no_oe_in_write_a: assert property (
		!oe_n |-> dq_oe_n)
		else $error("host drives data while device enabled");
	read_oe_width_a: assert property (
		$fell(oe_n) |-> !oe_n [*3])
		else $error("read enable too short");
	ready_mirror_a: assert property (
		##3 (device_ready == $past(ready_busy_n, 3)))
		else $error("ready not mirrored");
	answer_bound_a: assert property (
		start |-> ##[4:12] rsp_valid)
		else $error("no answer in time");

	write_seen_c: cover property ($rose(we_n));
	read_seen_c: cover property (read_end);
	protect_both_c: cover property (!top_block_protect_n && !lower_protect_n);

endmodule // amp_host

// File: logic/amp_pkg.sv
/*
 * Package for the multiplexed address port host controller.
 * Assumes a 20 MHz clock and an 11-bit shared address bus with an 8-bit data bus.
 */
package amp_pkg;

	localparam int AMP_ROW_W   = 11;
	localparam int AMP_COL_W   = 9;
	localparam int AMP_ADDR_W  = 20;
	localparam int AMP_DATA_W  = 8;
	localparam int AMP_CLK_MHZ = 20;

	// Phase lengths in nanoseconds and the cycle counts derived from them.
	localparam int AMP_T_SETUP_NS = 100;
	localparam int AMP_T_PULSE_NS = 100;
	localparam int AMP_T_HOLD_NS  = 50;
	localparam int AMP_T_READ_NS  = 150;
	localparam int AMP_SETUP_CYC  = (AMP_T_SETUP_NS * AMP_CLK_MHZ + 999) / 1000;
	localparam int AMP_PULSE_CYC  = (AMP_T_PULSE_NS * AMP_CLK_MHZ + 999) / 1000;
	localparam int AMP_HOLD_CYC   = (AMP_T_HOLD_NS * AMP_CLK_MHZ + 999) / 1000;
	localparam int AMP_READ_CYC   = (AMP_T_READ_NS * AMP_CLK_MHZ + 999) / 1000;

	localparam logic [3:0] AMP_TOP_SMALL = 4'h7;
	localparam logic [3:0] AMP_TOP_LARGE = 4'hF;
	localparam int         AMP_RDY_BIT   = 7;

	typedef struct packed {
		logic                  write;
		logic [AMP_ADDR_W-1:0] addr;
		logic [AMP_DATA_W-1:0] wdata;
	} amp_req_t;

	typedef struct packed {
		logic [AMP_ROW_W-1:0]  addr;
		logic                  row_col;
		logic                  we_n;
		logic                  oe_n;
		logic [AMP_DATA_W-1:0] dq_out;
		logic                  dq_oe_n;
	} amp_pins_t;

	typedef enum logic [6:0] {
		AMP_IDLE  = 7'h01,
		AMP_ROW   = 7'h02,
		AMP_COL   = 7'h04,
		AMP_STROB = 7'h08,
		AMP_HOLD  = 7'h10,
		AMP_READ  = 7'h20,
		AMP_DONE  = 7'h40
	} amp_state_t;

endpackage

// File: logic/amp_sync.sv
/*
 * Two flip-flop synchroniser for a bus of pin inputs.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
module amp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule // amp_sync

// File: verification/amp_dev_model.sv
/*
 * Behavioural model of the flash device on its multiplexed parallel port.
 * Assumes one byte per block and that only the block-five lock register starts locked.
 */
`timescale 1ns/1ps
module amp_dev_model (
	input  wire logic [10:0] addr_pins,
	input  wire logic        row_col,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [7:0]  dq_out,
	input  wire logic        dq_oe_n,
	input  wire logic        top_n,
	input  wire logic        low_n,
	output logic      [7:0]  dq_wire,
	output logic             ready_busy_n
);
	logic [10:0] row_reg;
	logic [8:0]  col_reg;
	logic [7:0]  mem [0:7];
	logic [7:0]  lock_reg;
	logic [7:0]  pat;
	logic [2:0]  blk;
	logic        allow;
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		lock_reg = 8'h20;
		ready_busy_n = 1'b1;
		pat = 8'h5A;
		row_reg = 11'h000;
		col_reg = 9'h000;
	end
	always #25 pat = ~pat;
	assign blk = col_reg[7:5];
	always @(addr_pins or row_col) begin
		if (row_col) row_reg = addr_pins;
		else col_reg = addr_pins[8:0];
	end
	// Lock registers are never written from the protect pins.
	assign allow = !lock_reg[blk] && ((blk == 3'h7) ? top_n : low_n);
	always @(posedge we_n) begin
		if (allow) mem[blk] = dq_wire;
		ready_busy_n = 1'b0;
		ready_busy_n <= #310 1'b1;
	end
	assign dq_wire = !dq_oe_n ? dq_out : (!oe_n ? mem[blk] : pat);
endmodule // amp_dev_model

// File: verification/amp_host_tb.sv
/*
 * Self-checking bench for the multiplexed port host controller.
 * Assumes the device model in amp_dev_model and the small density.
 */
`timescale 1ns/1ps
module amp_host_tb;
	logic              clk, rst, req_valid, top_protect_en, low_protect_en;
	amp_pkg::amp_req_t req;
	logic              req_ready, rsp_valid, device_ready, top_block_protect_n;
	logic              lower_protect_n, row_col, we_n, oe_n, dq_oe_n, ready_busy_n;
	logic [7:0]        rsp_data, dq_out, dq_wire, rd;
	logic [10:0]       addr_pins;
	int                error_cnt, tests_run, cyc;
	amp_host uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
		.top_protect_en(top_protect_en), .low_protect_en(low_protect_en),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.device_ready(device_ready), .top_block_protect_n(top_block_protect_n),
		.lower_protect_n(lower_protect_n), .addr_pins(addr_pins), .row_col(row_col),
		.we_n(we_n), .oe_n(oe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.dq_in(dq_wire), .ready_busy_n(ready_busy_n));
	amp_dev_model dev (.addr_pins(addr_pins), .row_col(row_col), .we_n(we_n),
		.oe_n(oe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .top_n(top_block_protect_n),
		.low_n(lower_protect_n), .dq_wire(dq_wire), .ready_busy_n(ready_busy_n));
	/*****************/
	/* Shared tasks. */
	/*****************/
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [19:0] a, input logic [7:0] d);
		while (req_ready !== 1'b1) @(negedge clk);
		req_valid = 1'b1;
		req = '{write: w, addr: a, wdata: d};
		@(negedge clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1) @(negedge clk);
		rd = rsp_data;
	endtask
	task automatic prot(input logic t, input logic l);
		top_protect_en = t;
		low_protect_en = l;
		repeat (3) @(negedge clk);
		chk("top_protect_pin", {7'h00, !t}, {7'h00, top_block_protect_n});
		chk("low_protect_pin", {7'h00, !l}, {7'h00, lower_protect_n});
	endtask
	/**************/
	/* Scenarios. */
	/**************/
	task automatic t_rw();
		prot(1'b0, 1'b0);
		xfer(1'b1, 20'h2ABCD, 8'hC3);
		xfer(1'b1, 20'h7F7FF, 8'h81);
		xfer(1'b0, 20'h2ABCD, 8'h00);
		chk("read_blk2", 8'hC3, rd);
		xfer(1'b0, 20'h7F7FF, 8'h00);
		chk("read_blk7", 8'h81, rd);
		$display("test rw done");
	endtask
	task automatic t_top();
		prot(1'b1, 1'b0);
		xfer(1'b1, 20'h70001, 8'h3C);
		xfer(1'b0, 20'h70001, 8'h00);
		chk("top_refused", 8'h81, rd);
		xfer(1'b1, 20'h20001, 8'h66);
		xfer(1'b0, 20'h20001, 8'h00);
		chk("low_allowed", 8'h66, rd);
		$display("test top done");
	endtask
	task automatic t_low();
		prot(1'b0, 1'b1);
		xfer(1'b1, 20'h20002, 8'h99);
		xfer(1'b0, 20'h20002, 8'h00);
		chk("low_refused", 8'h66, rd);
		xfer(1'b1, 20'h70002, 8'h24);
		xfer(1'b0, 20'h70002, 8'h00);
		chk("top_allowed", 8'h24, rd);
		$display("test low done");
	endtask
	task automatic t_lock();
		prot(1'b0, 1'b0);
		xfer(1'b1, 20'h50000, 8'h77);
		xfer(1'b0, 20'h50000, 8'h00);
		chk("lock_refused", 8'h00, rd);
		$display("test lock done");
	endtask
	task automatic t_busy();
		prot(1'b0, 1'b0);
		xfer(1'b1, 20'h30000, 8'h11);
		repeat (2) @(negedge clk);
		chk("busy_seen", 8'h00, {7'h00, device_ready});
		repeat (14) @(negedge clk);
		chk("ready_seen", 8'h01, {7'h00, device_ready});
		chk("strobe_idle", 8'h01, {7'h00, we_n});
		chk("data_released", 8'h01, {7'h00, dq_oe_n});
		$display("test busy done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		top_protect_en = 1'b0;
		low_protect_en = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		cyc = 0;
		repeat (6) @(negedge clk);
		chk("reset_oe", 8'h01, {7'h00, oe_n});
		rst = 1'b0;
		t_rw();
		t_top();
		t_low();
		t_lock();
		t_busy();
		stop_test();
	end
endmodule // amp_host_tb
